// ### rtl/spfs_consts.svh
`ifndef SPFS_CONSTS_SVH
`define SPFS_CONSTS_SVH

`define SPFS_CLK_PERIOD_NS  100
`define SPFS_HALF_BIT_NS    500
`define SPFS_HALF_BIT_CYC   ((`SPFS_HALF_BIT_NS + `SPFS_CLK_PERIOD_NS - 1) / `SPFS_CLK_PERIOD_NS)

`define SPFS_OFS_CTRL       8'h00
`define SPFS_OFS_TXDATA     8'h04
`define SPFS_OFS_RXDATA     8'h08
`define SPFS_OFS_STATUS     8'h0c

`define SPFS_CTRL_EN        0
`define SPFS_CTRL_SLAVE     1
`define SPFS_CTRL_CPOL      2
`define SPFS_CTRL_CPHA      3
`define SPFS_CTRL_HDX       4
`define SPFS_CTRL_SIZE_LO   8
`define SPFS_CTRL_SIZE_HI   11
`define SPFS_CTRL_RESET     16'h0704

`define SPFS_ST_OVR         3
`define SPFS_SIZE_MIN       4'h3
`define SPFS_MW_FIRST_CAP   5'h0a
`define SPFS_TAIL_HALVES    2'h2

`endif

// ### rtl/spfs_pkg.sv
package spfs_pkg;

    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TAIL, ST_GAP} spfs_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } spfs_sync_t;

    typedef struct packed {
        logic [7:0] cnt;
    } spfs_tick_t;

    typedef struct packed {
        spfs_state_t st;
        logic [15:0] ctrl;
        logic [15:0] tx_data;
        logic        tx_valid;
        logic [15:0] rx_data;
        logic        rx_valid;
        logic        rx_ovr;
        logic [15:0] sh_tx;
        logic [15:0] sh_rx;
        logic [4:0]  lcnt;
        logic [1:0]  tcnt;
        logic        done;
        logic        sclk;
        logic        fss;
        logic        sdo;
        logic        sdo_oe;
        logic        ack;
        logic [31:0] rdata;
        logic        sclk_q;
        logic        fss_q;
    } spfs_core_t;

endpackage : spfs_pkg

// ### rtl/spfs_sync.sv
`timescale 1ns/1ps
module spfs_sync (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    import spfs_pkg::*;

    spfs_sync_t r;
    spfs_sync_t n;

    always_comb begin
        n.s1 = d_i;
        n.s2 = r.s1;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q_o = r.s2;
endmodule : spfs_sync

// ### rtl/spfs_tick.sv
`timescale 1ns/1ps
`include "spfs_consts.svh"
module spfs_tick (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic clr_i,
    output logic      tick_o
);
    import spfs_pkg::*;

    localparam logic [7:0] LAST = 8'(`SPFS_HALF_BIT_CYC - 1);

    spfs_tick_t r;
    spfs_tick_t n;

    // Restart on clear so the first half bit after a frame start is exact
    always_comb begin
        n = r;
        if (clr_i || r.cnt == LAST) begin
            n.cnt = 8'h00;
        end else begin
            n.cnt = r.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick_o = !clr_i && (r.cnt == LAST);
endmodule : spfs_tick

// ### rtl/spfs_frame_seq.sv
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "spfs_consts.svh"
// Behaviour
// - Idle high polarity: clock high, select high, data low
// - Master drives clock pad, slave releases it
// - Enabled with word queued: select low, data pad on
// - First-edge capture: data half bit, clock after
// - Select rises one period after last capture
// - First-edge capture: select pulses high between words
// - Second-edge capture: data and clock half bit after
// - Second-edge capture: select stays low between words
// - Half-duplex: 8 command bits, wait, 4-16 reply
// - Half-duplex idle: clock low, select high, data low
// - Half-duplex: queued byte starts frame, MSB at fall
// - Half-duplex: select low all frame, slave quiet
// - Slave latches rising, replies falling, port latches rising
// - Single half-duplex: select up one period, store word
// - Continuous half-duplex: next command right after LSB
// - As slave, sample on the polarity/phase capture edge after select; rising in half-duplex
// - Words 4 to 16 bits, MSB first
module spfs_frame_seq (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        serial_bit_clock_i,
    output logic             serial_bit_clock_o,
    output logic             serial_bit_clock_oe_o,
    input  wire logic        frame_select_line_i,
    output logic             frame_select_line_o,
    output logic             frame_select_line_oe_o,
    input  wire logic        serial_in_line_i,
    output logic             serial_out_line_o,
    output logic             serial_out_line_oe_o
);
    import spfs_pkg::*;

    localparam int HALF = `SPFS_HALF_BIT_CYC;
    localparam int FULL = 2 * `SPFS_HALF_BIT_CYC;

    spfs_core_t  r;
    spfs_core_t  n;
    logic        tick;
    logic        div_clr;
    logic        sclk_s;
    logic        fss_s;
    logic        sdi_s;
    logic [3:0]  msb;
    logic [3:0]  sz;
    logic        en;
    logic        slv;
    logic        cpol;
    logic        cpha;
    logic        hdx;
    logic        idle_lvl;
    logic        req;
    logic        busy;
    logic [4:0]  nlead;
    logic [4:0]  l;
    logic [15:0] ld_word;
    logic [15:0] mask;
    logic        push;
    logic        edge_now;
    logic        s_rise;
    logic        s_fall;
    logic        s_lead;
    logic        s_trail;
    logic        s_cap;
    logic        s_shift;
    logic        fss_fall;
    logic        tx_msb7;

    spfs_sync u_sync_clk (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .d_i       (serial_bit_clock_i),
        .q_o       (sclk_s)
    );

    spfs_sync u_sync_fss (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .d_i       (frame_select_line_i),
        .q_o       (fss_s)
    );

    spfs_sync u_sync_sdi (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .d_i       (serial_in_line_i),
        .q_o       (sdi_s)
    );

    spfs_tick u_tick (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .clr_i     (div_clr),
        .tick_o    (tick)
    );

    assign div_clr  = (r.st == ST_IDLE);
    assign msb      = r.ctrl[`SPFS_CTRL_SIZE_HI:`SPFS_CTRL_SIZE_LO];
    assign en       = r.ctrl[`SPFS_CTRL_EN];
    assign slv      = r.ctrl[`SPFS_CTRL_SLAVE];
    assign cpol     = r.ctrl[`SPFS_CTRL_CPOL];
    assign cpha     = r.ctrl[`SPFS_CTRL_CPHA];
    assign hdx      = r.ctrl[`SPFS_CTRL_HDX];
    // Half-duplex always idles low whatever the polarity bit says
    assign idle_lvl = cpol & ~hdx;
    // Sizes below four bits are raised to four
    assign sz       = (avs_writedata_i[11:8] < `SPFS_SIZE_MIN) ? `SPFS_SIZE_MIN : avs_writedata_i[11:8];
    assign nlead    = hdx ? ({1'b0, msb} + `SPFS_MW_FIRST_CAP) : ({1'b0, msb} + 5'h01);
    assign mask     = 16'hffff >> (4'hf - msb);
    // Left-align so the MSB always leaves from bit 15
    assign ld_word  = hdx ? {r.tx_data[7:0], 8'h00} : (r.tx_data << (4'hf - msb));
    assign req      = avs_read_i | avs_write_i;
    assign busy     = (r.st != ST_IDLE) || (en && slv && !fss_s);
    assign tx_msb7  = r.tx_data[7];

    assign s_rise   = sclk_s & ~r.sclk_q;
    assign s_fall   = ~sclk_s & r.sclk_q;
    assign s_lead   = idle_lvl ? s_fall : s_rise;
    assign s_trail  = idle_lvl ? s_rise : s_fall;
    assign s_cap    = hdx ? s_rise : (cpha ? s_trail : s_lead);
    assign s_shift  = hdx ? 1'b0 : (cpha ? s_lead : s_trail);
    assign fss_fall = ~fss_s & r.fss_q;
    assign edge_now = tick && ((r.st == ST_SHIFT) || (r.st == ST_LEAD && cpha && !hdx));

    always_comb begin
        n        = r;
        push     = 1'b0;
        l        = r.lcnt + 5'h01;
        n.ack    = req & ~r.ack;
        n.sclk_q = sclk_s;
        n.fss_q  = fss_s;

        if (req && !r.ack) begin
            case (avs_address_i)
                `SPFS_OFS_CTRL:   n.rdata = {16'h0000, r.ctrl};
                `SPFS_OFS_TXDATA: n.rdata = {16'h0000, r.tx_data};
                `SPFS_OFS_RXDATA: n.rdata = {16'h0000, r.rx_data};
                `SPFS_OFS_STATUS: n.rdata = {28'h0000000, r.rx_ovr, busy, r.rx_valid, r.tx_valid};
                default:          n.rdata = 32'h00000000;
            endcase
        end
        if (avs_write_i && r.ack) begin
            case (avs_address_i)
                `SPFS_OFS_CTRL: begin
                    // Reconfiguring mid-frame would tear the frame
                    if (r.st == ST_IDLE) begin
                        n.ctrl = {4'h0, sz, 3'h0, avs_writedata_i[4:0]};
                    end
                end
                `SPFS_OFS_TXDATA: begin
                    if (!r.tx_valid) begin
                        n.tx_data  = avs_writedata_i[15:0];
                        n.tx_valid = 1'b1;
                    end
                end
                `SPFS_OFS_STATUS: begin
                    if (avs_writedata_i[`SPFS_ST_OVR]) begin
                        n.rx_ovr = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (avs_read_i && r.ack && avs_address_i == `SPFS_OFS_RXDATA) begin
            n.rx_valid = 1'b0;
        end

        if (en && slv) begin
            n.st     = ST_IDLE;
            n.sclk   = idle_lvl;
            n.fss    = 1'b1;
            n.sdo_oe = !fss_s && !hdx;
            if (fss_s) begin
                n.lcnt = 5'h00;
            end
            if (fss_fall) begin
                n.sh_tx = (r.tx_valid && !hdx) ? ld_word : 16'h0000;
                n.sdo   = r.tx_valid && !hdx && ld_word[15];
                if (!hdx) begin
                    n.tx_valid = 1'b0;
                end
            end else if (!fss_s && s_cap) begin
                n.sh_rx = {r.sh_rx[14:0], sdi_s};
                n.lcnt  = l;
                if (l == {1'b0, msb} + 5'h01) begin
                    push   = 1'b1;
                    n.lcnt = 5'h00;
                    n.sh_tx = (r.tx_valid && !hdx) ? ld_word : 16'h0000;
                    if (!hdx) begin
                        n.tx_valid = 1'b0;
                    end
                end
            end else if (!fss_s && s_shift) begin
                if (r.lcnt != 5'h00) begin
                    n.sh_tx = r.sh_tx << 1;
                    n.sdo   = r.sh_tx[14];
                end else begin
                    n.sdo = r.sh_tx[15];
                end
            end
        end else begin
            case (r.st)
                ST_IDLE: begin
                    n.sclk   = idle_lvl;
                    n.fss    = 1'b1;
                    n.sdo    = 1'b0;
                    n.sdo_oe = 1'b0;
                    n.lcnt   = 5'h00;
                    n.done   = 1'b0;
                    if (en && r.tx_valid) begin
                        n.fss      = 1'b0;
                        n.sdo_oe   = 1'b1;
                        n.sh_tx    = ld_word;
                        n.tx_valid = 1'b0;
                        if (hdx) begin
                            n.st  = ST_SHIFT;
                            n.sdo = ld_word[15];
                        end else begin
                            n.st = ST_LEAD;
                        end
                    end
                end
                ST_LEAD: begin
                    if (tick && !cpha) begin
                        n.sdo = r.sh_tx[15];
                        n.st  = ST_SHIFT;
                    end
                end
                ST_SHIFT: ;
                ST_TAIL: begin
                    if (tick) begin
                        n.tcnt = r.tcnt + 2'h1;
                        if (r.tcnt + 2'h1 == `SPFS_TAIL_HALVES) begin
                            n.fss    = 1'b1;
                            n.sdo    = 1'b0;
                            n.sdo_oe = 1'b0;
                            n.st     = ST_GAP;
                            push     = hdx;
                        end
                    end
                end
                // Select stays high here for a half bit, giving the pulse between words
                ST_GAP: begin
                    if (tick) begin
                        n.st = ST_IDLE;
                    end
                end
                default: n.st = ST_IDLE;
            endcase

            if (edge_now) begin
                n.st = ST_SHIFT;
                if (r.sclk == idle_lvl) begin
                    n.sclk = ~idle_lvl;
                    n.lcnt = l;
                    if (hdx || !cpha) begin
                        if (!hdx || l >= `SPFS_MW_FIRST_CAP) begin
                            n.sh_rx = {r.sh_rx[14:0], sdi_s};
                        end
                        if (l == nlead) begin
                            n.done = 1'b1;
                            push   = !hdx;
                        end
                    end else begin
                        n.sdo = (l == 5'h01) ? r.sh_tx[15] : r.sh_tx[14];
                        if (l != 5'h01) begin
                            n.sh_tx = r.sh_tx << 1;
                        end
                    end
                end else begin
                    n.sclk = idle_lvl;
                    if (hdx && r.done && r.tx_valid) begin
                        push       = 1'b1;
                        n.sh_tx    = ld_word;
                        n.sdo      = ld_word[15];
                        n.tx_valid = 1'b0;
                        n.lcnt     = 5'h00;
                        n.done     = 1'b0;
                    end else if (r.done) begin
                        n.st   = ST_TAIL;
                        n.tcnt = 2'h1;
                    end else if (hdx || !cpha) begin
                        n.sh_tx = r.sh_tx << 1;
                        n.sdo   = r.sh_tx[14];
                    end else begin
                        n.sh_rx = {r.sh_rx[14:0], sdi_s};
                        if (r.lcnt == nlead) begin
                            push = 1'b1;
                            if (r.tx_valid) begin
                                n.sh_tx    = ld_word;
                                n.tx_valid = 1'b0;
                                n.lcnt     = 5'h00;
                            end else begin
                                n.st   = ST_TAIL;
                                n.tcnt = 2'h0;
                            end
                        end
                    end
                end
            end
        end

        // A fresh word wins over a same-cycle read clear; unread data is flagged
        if (push) begin
            n.rx_ovr   = n.rx_ovr | n.rx_valid;
            n.rx_valid = 1'b1;
            n.rx_data  = n.sh_rx & mask;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            r        <= '0;
            r.ctrl   <= `SPFS_CTRL_RESET;
            r.sclk   <= 1'b1;
            r.fss    <= 1'b1;
            r.fss_q  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign avs_readdata_o         = r.rdata;
    assign avs_waitrequest_o      = req & ~r.ack;
    assign serial_bit_clock_o     = r.sclk;
    assign serial_bit_clock_oe_o  = ~slv;
    assign frame_select_line_o    = r.fss;
    assign frame_select_line_oe_o = ~slv;
    assign serial_out_line_o      = r.sdo;
    assign serial_out_line_oe_o   = r.sdo_oe;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    a_idle_levels: assert property (
        r.st == ST_IDLE && $past(r.st) == ST_IDLE && $stable(r.ctrl) && !slv
        |-> r.fss && !r.sdo && r.sclk == idle_lvl)
        else $error("idle line levels wrong");

    a_start_pads: assert property (
        $fell(r.fss) && !slv |-> r.sdo_oe && $past(r.tx_valid) && !r.tx_valid)
        else $error("frame start without queued word or data pad");

    a_sph0_lead: assert property (
        $fell(r.fss) && !slv && !hdx && !cpha
        |-> $stable(r.sclk) [*1] ##FULL ($changed(r.sclk) && r.sclk != idle_lvl))
        else $error("first edge not one bit after select fall");

    a_sph1_lead: assert property (
        $fell(r.fss) && !slv && !hdx && cpha
        |-> ##HALF ($changed(r.sclk) && r.sclk != idle_lvl && r.sdo == r.sh_tx[15]))
        else $error("second-edge mode clock or data late");

    a_cmd_msb: assert property (
        $fell(r.fss) && !slv && hdx |-> r.sdo_oe && r.sdo == $past(tx_msb7))
        else $error("command MSB not on line at select fall");

    a_end_full: assert property (
        r.st == ST_TAIL && $past(r.st) == ST_SHIFT && !slv && !hdx && cpha
        |-> !r.fss ##FULL $rose(r.fss))
        else $error("select not raised one period after capture");

    a_end_half: assert property (
        r.st == ST_TAIL && $past(r.st) == ST_SHIFT && !slv && (hdx || !cpha)
        |-> !r.fss ##HALF ($rose(r.fss) && (!hdx || r.rx_valid)))
        else $error("frame end or receive store mistimed");

    a_gap_pulse: assert property (
        $rose(r.fss) && !slv |-> r.fss [*5])
        else $error("select pulse between words too short");

    a_mw_frame: assert property (
        r.st == ST_SHIFT && hdx && !slv |-> !r.fss && r.sdo_oe)
        else $error("select released inside command frame");
endmodule : spfs_frame_seq

// ### test/spfs_slave_model.sv
`timescale 1ns/1ps
module spfs_slave_model (
    input  wire logic        sclk_i,
    input  wire logic        fss_n_i,
    input  wire logic        mosi_i,
    input  wire logic        cpha_i,
    input  wire logic        hdx_i,
    input  wire logic [4:0]  nbits_i,
    input  wire logic [15:0] reply_i,
    output logic             miso_o,
    output logic [15:0]      got_o
);
    logic bit_q = 1'b0;
    logic drv   = 1'b0;
    int   nc    = 0;
    int   no    = 0;

    // A released line shows the inverse of its last bit, so a stale sample never matches by luck
    assign miso_o = drv ? bit_q : ~bit_q;

    initial got_o = 16'h0;

    task automatic drive;
        bit_q = reply_i[nbits_i - 1 - no];
        drv   = 1'b1;
        no    = (no + 1) % nbits_i;
    endtask : drive

    always @(negedge fss_n_i) begin
        nc  = 0;
        no  = 0;
        drv = 1'b0;
        if (!hdx_i && !cpha_i) drive();
    end

    always @(posedge fss_n_i) drv = 1'b0;

    always @(negedge sclk_i) if (!fss_n_i) begin
        if (!hdx_i) begin
            if (cpha_i) drive();
            else got_o = {got_o[14:0], mosi_i};
        end else if (nc >= 9 && nc < 9 + nbits_i) drive();
        else if (nc == 9 + nbits_i) begin
            drv = 1'b0;
            nc  = 0;
        end
    end

    always @(posedge sclk_i) if (!fss_n_i) begin
        if (!hdx_i) begin
            if (cpha_i) got_o = {got_o[14:0], mosi_i};
            else drive();
        end else begin
            if (nc < 8) got_o = {got_o[14:0], mosi_i};
            nc++;
        end
    end
endmodule : spfs_slave_model

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
    logic        clk_sys;
    logic        reset_n;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        wreq;
    logic        sclk_o, sclk_oe, fss_o, fss_oe, sdo, sdo_oe, miso;
    logic        ext_clk, ext_fss, ext_d, cpha, hdx, pf, ps, oe_ok;
    logic [4:0]  nb;
    logic [15:0] reply, got;
    int          n_fail, n_tests, cyc, lead, low, n_rise, r0;
    wire         bclk = (sclk_oe === 1'b1) ? sclk_o : ext_clk;
    wire         fsl  = (fss_oe === 1'b1) ? fss_o : ext_fss;
    wire         sin  = (sclk_oe === 1'b1) ? miso : ext_d;

    spfs_frame_seq uut (
        .clk_sys_i(clk_sys), .reset_n_i(reset_n), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .serial_bit_clock_i(bclk), .serial_bit_clock_o(sclk_o), .serial_bit_clock_oe_o(sclk_oe),
        .frame_select_line_i(fsl), .frame_select_line_o(fss_o), .frame_select_line_oe_o(fss_oe),
        .serial_in_line_i(sin), .serial_out_line_o(sdo), .serial_out_line_oe_o(sdo_oe)
    );

    spfs_slave_model peer (
        .sclk_i(bclk), .fss_n_i(fsl), .mosi_i(sdo), .cpha_i(cpha), .hdx_i(hdx),
        .nbits_i(nb), .reply_i(reply), .miso_o(miso), .got_o(got)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Frame timing seen on the pins, in system cycles from the select fall
    always @(posedge clk_sys) begin
        pf  <= fss_o;
        ps  <= sclk_o;
        cyc <= cyc + 1;
        if (pf && !fss_o) begin
            cyc   <= 1;
            lead  <= 0;
            oe_ok <= sdo_oe;
        end else if (ps != sclk_o && lead == 0) lead <= cyc;
        if (!pf && fss_o) begin
            n_rise <= n_rise + 1;
            low    <= cyc;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        rd   <= !w;
        wr   <= w;
        addr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdat;
        if (n >= 20) n_fail++;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask : acc

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask : wreg

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rchk

    task automatic waitst(input logic [2:0] m);
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            acc(1'b0, 8'h0c, 32'h0, q);
            n++;
        end while ((q[2:0] & m) !== 3'h0 && n < 400);
        if (n >= 400) n_fail++;
    endtask : waitst

    // Bench acts as external master: data on falling edge, captured on rising
    task automatic ext_xfer(input logic [7:0] w);
        ext_fss <= 1'b0;
        repeat (16) @(posedge clk_sys);
        for (int i = 7; i >= 0; i--) begin
            ext_clk <= 1'b0;
            ext_d   <= w[i];
            repeat (4) @(posedge clk_sys);
            ext_clk <= 1'b1;
            repeat (4) @(posedge clk_sys);
        end
        repeat (4) @(posedge clk_sys);
        ext_fss <= 1'b1;
        ext_d   <= ~w[0];
        repeat (20) @(posedge clk_sys);
    endtask : ext_xfer

    task summarize;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    initial begin
        reset_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdat = 32'h0;
        ext_clk = 1'b1;
        ext_fss = 1'b1;
        ext_d = 1'b0;
        cpha = 1'b0;
        hdx = 1'b0;
        nb = 5'h08;
        reply = 16'h003c;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chk({27'h0, sclk_o, fss_o, sdo, sdo_oe, sclk_oe}, 32'h19);
        rchk(8'h00, 32'h0704);
        rchk(8'h0c, 32'h0);
        rchk(8'h10, 32'h0);
        $display("reset test done");
        for (int ph = 0; ph < 2; ph++) begin
            cpha <= ph[0];
            wreg(8'h00, 32'h0705 | (ph << 3));
            wreg(8'h04, 32'h00a5);
            waitst(3'h5);
            chk(lead, ph ? 5 : 10);
            chk(low, 90);
            chk(oe_ok, 1);
            chk(got[7:0], 8'ha5);
            rchk(8'h04, 32'h00a5);
            rchk(8'h08, 32'h003c);
            r0 = n_rise;
            wreg(8'h04, 32'h0081);
            waitst(3'h1);
            wreg(8'h04, 32'h0042);
            waitst(3'h5);
            chk(n_rise - r0, ph ? 1 : 2);
            chk(got[7:0], 8'h42);
            rchk(8'h0c, 32'h000a);
            rchk(8'h08, 32'h003c);
            $display("spi phase %0d test done", ph);
        end
        hdx <= 1'b1;
        cpha <= 1'b0;
        reply <= 16'hc35a;
        for (int n = 4; n <= 16; n += 6) begin
            nb <= n[4:0];
            wreg(8'h00, 32'h0011 | ((n - 1) << 8));
            // Idle clock level follows the new control word one edge later
            @(posedge clk_sys);
            chk({31'h0, sclk_o}, 0);
            wreg(8'h04, 32'h0096);
            waitst(3'h5);
            chk(lead, 5);
            chk(low, 95 + 10 * n);
            chk(got[7:0], 8'h96);
            rchk(8'h08, 32'hc35a & ((32'h1 << n) - 1));
            r0 = n_rise;
            wreg(8'h04, 32'h0069);
            waitst(3'h1);
            wreg(8'h04, 32'h00d2);
            waitst(3'h5);
            chk(n_rise - r0, 1);
            chk(got[7:0], 8'hd2);
            rchk(8'h08, 32'hc35a & ((32'h1 << n) - 1));
            $display("half-duplex %0d-bit test done", n);
        end
        hdx <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            wreg(8'h00, s ? 32'h0713 : 32'h070f);
            chk({30'h0, sclk_oe, fss_oe}, 0);
            ext_xfer(8'h5a);
            rchk(8'h08, 32'h005a);
            $display("slave mode %0d test done", s);
        end
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        summarize();
    end
endmodule : tb
